// file: hw/slts_top.sv
// Serial link self-test sequencer: frame generator and checker
// Assumes a 50 MHz sys_clk; line pins and data set receive timing
// are asynchronous and are synchronised here
`timescale 1ns/1ps
`include "slts_map.svh"

module slts_top (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [7:0] addr,
  input wire logic [31:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rd_data,
  input wire logic line_rx,
  input wire logic line_rx_clk,
  input wire logic line_ack,
  input wire logic manual_clear,
  output logic tx_line,
  output logic tx_ind,
  output logic rx_ind,
  output logic irq
);

  // Registers
  slts_pkg::slts_ctrl_t ctrl_ff; // Test selectors
  slts_pkg::slts_stat_t status_ff; // Sticky events
  slts_pkg::slts_stat_t mask_ff; // Interrupt enables
  slts_pkg::slts_tx_st_t tx_st_ff;
  slts_pkg::slts_tx_st_t nxt_tx_st;
  slts_pkg::slts_rx_st_t rx_st_ff;
  slts_pkg::slts_rx_st_t nxt_rx_st;
  logic [7:0] div_ff; // Transmit bit timer
  logic [3:0] tx_cnt_ff; // Bit within word
  logic [3:0] nxt_tx_cnt;
  logic [11:0] tx_sh_ff; // Outgoing word, MSB first
  logic [11:0] nxt_tx_sh;
  logic [3:0] rx_cnt_ff;
  logic [3:0] nxt_rx_cnt;
  logic [11:0] rx_sh_ff; // Incoming bits
  logic [11:0] rx_word_ff; // Last data word received
  logic [11:0] nxt_rx_word;
  logic rx_clk_d_ff; // Previous synced receive clock

  // Synchronised pins
  logic [3:0] pin_s;
  logic rx_bit, rx_clk_s, ack_s, clr_s;

  // Decoded strobes and events
  logic wr_ctrl, wr_stat, wr_mask, clear;
  logic tx_on, alt, rx_en, tx_busy;
  logic tx_tick, tx_last, rx_tick, rx_last, rx_done;
  logic [11:0] test_word, rx_in, tx_crc, tx_crc_upd, rx_crc;
  logic crc_bad;
  slts_pkg::slts_stat_t ev, w1c, nxt_status;
  logic [31:0] rd_mux;

  // Every pin passes two flip-flops first
  slts_sync #(.WIDTH(4)) u_sync (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .pin_in({line_rx, line_rx_clk, line_ack, manual_clear}),
    .pin_sync(pin_s)
  );
  assign {rx_bit, rx_clk_s, ack_s, clr_s} = pin_s;

  // Register decode
  assign wr_ctrl = wr_en && (addr == `SLTS_ADDR_CTRL);
  assign wr_stat = wr_en && (addr == `SLTS_ADDR_STATUS);
  assign wr_mask = wr_en && (addr == `SLTS_ADDR_MASK);
  // Pushbutton or software pulse
  assign clear = clr_s || (wr_ctrl && wr_data[`SLTS_CTRL_CLEAR_BIT]);

  // Selector decode; unknown codes behave as off
  assign tx_on = (ctrl_ff.tx_pos >= slts_pkg::SLTS_TX_P1) &&
                 (ctrl_ff.tx_pos <= slts_pkg::SLTS_TX_P4);
  assign alt = ctrl_ff.rx_mode == slts_pkg::SLTS_RX_REC;
  assign rx_en = alt || (ctrl_ff.rx_mode == slts_pkg::SLTS_RX_INT);
  assign tx_busy = (tx_st_ff == slts_pkg::SLTS_TS_SYNC) ||
                   (tx_st_ff == slts_pkg::SLTS_TS_DATA) ||
                   (tx_st_ff == slts_pkg::SLTS_TS_CODE);

  // Test word per position
  assign test_word =
    (ctrl_ff.tx_pos == slts_pkg::SLTS_TX_P1) ? `SLTS_WORD_ZEROS :
    (ctrl_ff.tx_pos == slts_pkg::SLTS_TX_P2) ? `SLTS_WORD_ONES :
    (ctrl_ff.tx_pos == slts_pkg::SLTS_TX_P3) ? `SLTS_WORD_INT :
    `SLTS_WORD_INT_N;

  // Bit timing
  assign tx_tick = tx_busy && (div_ff == `SLTS_BIT_LAST);
  assign tx_last = tx_tick && (tx_cnt_ff == `SLTS_WORD_LAST);
  assign rx_tick = rx_clk_s && !rx_clk_d_ff;
  assign rx_last = rx_tick && (rx_cnt_ff == `SLTS_WORD_LAST);
  assign rx_in = {rx_sh_ff[10:0], rx_bit};
  assign rx_done = (rx_st_ff == slts_pkg::SLTS_RS_CODE) && rx_last &&
                   !clear;
  assign crc_bad = rx_in != rx_crc;

  // Encoder runs over the outgoing data word
  slts_crc #(.POLY(`SLTS_CRC_POLY)) u_tx_crc (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .clr(tx_st_ff != slts_pkg::SLTS_TS_DATA),
    .en(tx_tick && (tx_st_ff == slts_pkg::SLTS_TS_DATA)),
    .din(tx_sh_ff[11]),
    .crc_ff(tx_crc),
    .crc_upd(tx_crc_upd)
  );

  // Decoder runs over the incoming data word, holds through the code word
  slts_crc #(.POLY(`SLTS_CRC_POLY)) u_rx_crc (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .clr(rx_st_ff == slts_pkg::SLTS_RS_HUNT),
    .en(rx_tick && (rx_st_ff == slts_pkg::SLTS_RS_DATA)),
    .din(rx_bit),
    .crc_ff(rx_crc),
    .crc_upd()
  );

  // Transmit sequencer: sync, data, code, then again
  always_comb begin
    nxt_tx_st = tx_st_ff;
    nxt_tx_sh = tx_sh_ff;
    nxt_tx_cnt = tx_cnt_ff;
    if (tx_tick) begin
      nxt_tx_sh = {tx_sh_ff[10:0], 1'b0};
      nxt_tx_cnt = 4'(tx_cnt_ff + 4'h1);
    end
    unique case (tx_st_ff)
      slts_pkg::SLTS_TS_IDLE: begin
        if (tx_on) begin
          nxt_tx_st = slts_pkg::SLTS_TS_SYNC;
          nxt_tx_sh = `SLTS_SYNC_WORD;
        end
      end
      slts_pkg::SLTS_TS_SYNC: begin
        if (tx_last) begin
          nxt_tx_st = slts_pkg::SLTS_TS_DATA;
          nxt_tx_sh = test_word;
          nxt_tx_cnt = 4'h0;
        end
      end
      slts_pkg::SLTS_TS_DATA: begin
        if (tx_last) begin
          nxt_tx_st = slts_pkg::SLTS_TS_CODE;
          nxt_tx_sh = tx_crc_upd;
          nxt_tx_cnt = 4'h0;
        end
      end
      slts_pkg::SLTS_TS_CODE: begin
        // Frame always finishes before the selector is obeyed
        if (tx_last) begin
          nxt_tx_cnt = 4'h0;
          if (!tx_on) begin
            nxt_tx_st = slts_pkg::SLTS_TS_IDLE;
          end else if (alt) begin
            nxt_tx_st = slts_pkg::SLTS_TS_WAIT;
          end else begin
            nxt_tx_st = slts_pkg::SLTS_TS_SYNC;
            nxt_tx_sh = `SLTS_SYNC_WORD;
          end
        end
      end
      slts_pkg::SLTS_TS_WAIT: begin
        // Waits for the partner's frame; stalls if none comes
        if (!tx_on) begin
          nxt_tx_st = slts_pkg::SLTS_TS_IDLE;
        end else if (rx_done || !alt) begin
          nxt_tx_st = slts_pkg::SLTS_TS_SYNC;
          nxt_tx_sh = `SLTS_SYNC_WORD;
        end
      end
      default: begin
        nxt_tx_st = slts_pkg::SLTS_TS_IDLE;
      end
    endcase
    if (clear) begin
      nxt_tx_st = slts_pkg::SLTS_TS_IDLE;
      nxt_tx_cnt = 4'h0;
    end
  end

  // Receive sequencer: hunt sync, take data, take code
  always_comb begin
    nxt_rx_st = rx_st_ff;
    nxt_rx_cnt = rx_cnt_ff;
    nxt_rx_word = rx_word_ff;
    if (rx_tick) begin
      nxt_rx_cnt = 4'(rx_cnt_ff + 4'h1);
    end
    unique case (rx_st_ff)
      slts_pkg::SLTS_RS_HUNT: begin
        nxt_rx_cnt = 4'h0;
        if (rx_tick && (rx_in == `SLTS_SYNC_WORD)) begin
          nxt_rx_st = slts_pkg::SLTS_RS_DATA;
        end
      end
      slts_pkg::SLTS_RS_DATA: begin
        if (rx_last) begin
          nxt_rx_st = slts_pkg::SLTS_RS_CODE;
          nxt_rx_word = rx_in;
          nxt_rx_cnt = 4'h0;
        end
      end
      slts_pkg::SLTS_RS_CODE: begin
        if (rx_last) begin
          nxt_rx_st = slts_pkg::SLTS_RS_HUNT;
        end
      end
      default: begin
        nxt_rx_st = slts_pkg::SLTS_RS_HUNT;
      end
    endcase
    if (clear || !rx_en) begin
      nxt_rx_st = slts_pkg::SLTS_RS_HUNT;
    end
  end

  // Events; acknowledge counts once the sync word is out
  assign ev.frame_sent = (tx_st_ff == slts_pkg::SLTS_TS_CODE) &&
                         tx_last && !clear;
  assign ev.frame_rcvd = rx_done;
  assign ev.crc_err = rx_done && alt && crc_bad;
  assign ev.int_det = rx_done &&
    (ctrl_ff.rx_mode == slts_pkg::SLTS_RX_INT) &&
    (rx_word_ff == `SLTS_WORD_INT);
  assign ev.sync_ack = ack_s &&
    ((tx_st_ff == slts_pkg::SLTS_TS_DATA) ||
     (tx_st_ff == slts_pkg::SLTS_TS_CODE));
  assign w1c = wr_stat ? slts_pkg::slts_stat_t'(wr_data[4:0]) : 5'h00;
  // Set wins over write-one-to-clear
  assign nxt_status = (status_ff & ~w1c) | ev;

  // Read selection; unmapped offsets read zero
  assign rd_mux =
    (addr == `SLTS_ADDR_CTRL) ? {26'h0, ctrl_ff.rx_mode, 1'b0,
                                 ctrl_ff.tx_pos} :
    (addr == `SLTS_ADDR_STATUS) ? {27'h0, status_ff} :
    (addr == `SLTS_ADDR_MASK) ? {27'h0, mask_ff} :
    (addr == `SLTS_ADDR_STATE) ? {4'h0, rx_word_ff, 10'h0, rx_st_ff,
                                  1'b0, tx_st_ff} :
    32'h0000_0000;

  // Software registers
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      ctrl_ff <= `SLTS_CTRL_RESET;
      status_ff <= `SLTS_STAT_RESET;
      mask_ff <= `SLTS_STAT_RESET;
      rd_data <= 32'h0000_0000;
      irq <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl_ff <= slts_pkg::slts_ctrl_t'({wr_data[5:4], wr_data[2:0]});
      end
      if (wr_mask) begin
        mask_ff <= slts_pkg::slts_stat_t'(wr_data[4:0]);
      end
      status_ff <= nxt_status;
      rd_data <= rd_en ? rd_mux : 32'h0000_0000;
      irq <= |(nxt_status & mask_ff);
    end
  end

  // Sequencer state and line outputs
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      tx_st_ff <= slts_pkg::SLTS_TS_IDLE;
      rx_st_ff <= slts_pkg::SLTS_RS_HUNT;
      div_ff <= 8'h00;
      tx_cnt_ff <= 4'h0;
      tx_sh_ff <= 12'h000;
      rx_cnt_ff <= 4'h0;
      rx_sh_ff <= 12'h000;
      rx_word_ff <= 12'h000;
      rx_clk_d_ff <= 1'b0;
      tx_line <= 1'b1;
      tx_ind <= 1'b0;
      rx_ind <= 1'b0;
    end else begin
      tx_st_ff <= nxt_tx_st;
      rx_st_ff <= nxt_rx_st;
      // Timer idles outside a frame so each word starts aligned
      div_ff <= (!tx_busy || tx_tick || clear) ? 8'h00 :
                8'(div_ff + 8'h01);
      tx_cnt_ff <= nxt_tx_cnt;
      tx_sh_ff <= nxt_tx_sh;
      rx_cnt_ff <= nxt_rx_cnt;
      rx_sh_ff <= rx_tick ? rx_in : rx_sh_ff;
      rx_word_ff <= nxt_rx_word;
      rx_clk_d_ff <= rx_clk_s;
      // Line marks high while idle
      tx_line <= tx_busy ? tx_sh_ff[11] : 1'b1;
      tx_ind <= tx_busy;
      rx_ind <= rx_st_ff != slts_pkg::SLTS_RS_HUNT;
    end
  end

  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  a_tx_frame_start:
    assert property ((tx_st_ff == slts_pkg::SLTS_TS_IDLE) && tx_on &&
      !clear |=> tx_st_ff == slts_pkg::SLTS_TS_SYNC &&
      tx_sh_ff == `SLTS_SYNC_WORD)
    else $error("test frame did not start");
  a_tx_frame_repeat:
    assert property (ev.frame_sent && tx_on && !alt |=>
      tx_st_ff == slts_pkg::SLTS_TS_SYNC ##1 tx_line == 1'b0)
    else $error("frame did not repeat");
  a_tx_stop_off:
    assert property (ev.frame_sent && !tx_on |=>
      tx_st_ff == slts_pkg::SLTS_TS_IDLE [*2])
    else $error("generation did not stop");
  a_data_word_sel:
    assert property ((tx_st_ff == slts_pkg::SLTS_TS_SYNC) && tx_last &&
      !clear |=> tx_sh_ff == $past(test_word))
    else $error("wrong test word");
  a_code_word_enc:
    assert property ((tx_st_ff == slts_pkg::SLTS_TS_DATA) && tx_last &&
      !clear |=> tx_sh_ff == $past(tx_crc_upd) &&
      tx_crc == $past(tx_crc_upd))
    else $error("code word not from encoder");
  a_sync_ack_flag:
    assert property (ev.sync_ack |=> status_ff.sync_ack)
    else $error("acknowledge not recorded");
  a_crc_err_flag:
    assert property (rx_done && alt && crc_bad |=> status_ff.crc_err
      ##1 status_ff.crc_err || $past(wr_stat))
    else $error("code error not flagged");
  a_int_word_det:
    assert property (ev.int_det |=> status_ff.int_det &&
      rx_word_ff == `SLTS_WORD_INT)
    else $error("interrupt word missed");
  a_alt_wait_rx:
    assert property (ev.frame_sent && tx_on && alt |=>
      tx_st_ff == slts_pkg::SLTS_TS_WAIT ##1 !tx_ind)
    else $error("no alternation");
  a_tx_ind_level:
    assert property (tx_tick |=> tx_ind)
    else $error("transmit indicator low in frame");
  a_clear_idles:
    assert property (clear |=> tx_st_ff == slts_pkg::SLTS_TS_IDLE &&
      rx_st_ff == slts_pkg::SLTS_RS_HUNT ##1 !tx_ind && !rx_ind)
    else $error("clear left sequencing active");

  c_frame_sent: cover property (ev.frame_sent);
  c_crc_error: cover property (ev.crc_err);
  c_int_seen: cover property (ev.int_det);
  c_alternate: cover property (rx_done &&
    tx_st_ff == slts_pkg::SLTS_TS_WAIT);

endmodule

// file: hw/slts_map.svh
// Register offsets, field positions, reset values and timing counts
// Assumes inclusion by slts_top, slts_modem and the bench; definitions only
`ifndef SLTS_MAP_SVH
`define SLTS_MAP_SVH

// Byte offsets on the register port, one 32-bit register every four
`define SLTS_ADDR_CTRL 8'h00
`define SLTS_ADDR_STATUS 8'h04
`define SLTS_ADDR_MASK 8'h08
`define SLTS_ADDR_STATE 8'h0C

// Control word fields
`define SLTS_CTRL_CLEAR_BIT 8
`define SLTS_CTRL_RESET 5'h00
`define SLTS_STAT_RESET 5'h00

// Frame words, 12 bits each
`define SLTS_SYNC_WORD 12'h7E5
`define SLTS_WORD_ZEROS 12'h000
`define SLTS_WORD_ONES 12'hFFF
`define SLTS_WORD_INT 12'h06D
`define SLTS_WORD_INT_N 12'hF92
`define SLTS_WORD_LAST 4'hB

// Cyclic code generator polynomial, implied top term
`define SLTS_CRC_POLY 12'h80F

// Transmit bit period in sys_clk cycles, minus one
`define SLTS_BIT_LAST 8'h0F

`endif

// file: hw/slts_pkg.sv
// Types shared by the test sequencer files
// Assumes no other package
package slts_pkg;

  // Transmit test selector positions
  typedef enum logic [2:0] {
    SLTS_TX_OFF = 3'h0,
    SLTS_TX_P1 = 3'h1,
    SLTS_TX_P2 = 3'h2,
    SLTS_TX_P3 = 3'h3,
    SLTS_TX_P4 = 3'h4
  } slts_tx_pos_t;

  // Receive test selector positions
  typedef enum logic [1:0] {
    SLTS_RX_OFF = 2'h0,
    SLTS_RX_REC = 2'h1,
    SLTS_RX_INT = 2'h2
  } slts_rx_mode_t;

  // Transmit sequencing states
  typedef enum logic [2:0] {
    SLTS_TS_IDLE = 3'h0,
    SLTS_TS_SYNC = 3'h1,
    SLTS_TS_DATA = 3'h2,
    SLTS_TS_CODE = 3'h3,
    SLTS_TS_WAIT = 3'h4
  } slts_tx_st_t;

  // Receive sequencing states
  typedef enum logic [1:0] {
    SLTS_RS_HUNT = 2'h0,
    SLTS_RS_DATA = 2'h1,
    SLTS_RS_CODE = 2'h2
  } slts_rx_st_t;

  // Control register contents
  typedef struct packed {
    slts_rx_mode_t rx_mode;
    slts_tx_pos_t tx_pos;
  } slts_ctrl_t;

  // Sticky event bits, same layout for mask
  typedef struct packed {
    logic sync_ack;
    logic int_det;
    logic crc_err;
    logic frame_rcvd;
    logic frame_sent;
  } slts_stat_t;

endpackage

// file: hw/slts_sync.sv
// Two-stage synchroniser for a group of pin inputs
// Assumes inputs are asynchronous to sys_clk
`timescale 1ns/1ps
module slts_sync #(
  parameter int WIDTH = 1
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_sync
);

  logic [WIDTH-1:0] meta_ff; // First stage, read only by second

  // Both stages reset to zero
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      meta_ff <= '0;
      pin_sync <= '0;
    end else begin
      meta_ff <= pin_in;
      pin_sync <= meta_ff;
    end
  end

endmodule

// file: hw/slts_crc.sv
// Bit-serial cyclic code generator, MSB first
// Assumes caller clears it before each data word
`timescale 1ns/1ps
module slts_crc #(
  parameter logic [11:0] POLY = 12'h80F
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic clr,
  input wire logic en,
  input wire logic din,
  output logic [11:0] crc_ff,
  output logic [11:0] crc_upd
);

  logic fb; // Feedback term

  // Next value if the current bit is folded in now
  assign fb = crc_ff[11] ^ din;
  assign crc_upd = {crc_ff[10:0], 1'b0} ^ (fb ? POLY : 12'h000);

  // Clear wins over shift
  always_ff @(posedge sys_clk) begin
    if (!rst_b || clr) begin
      crc_ff <= 12'h000;
    end else if (en) begin
      crc_ff <= crc_upd;
    end
  end

endmodule

// file: verification/slts_modem.sv
// Far-side data set model: receive data, receive bit clock, remote ack
// Assumes the same sys_clk as the sequencer; the bench calls send_frame
`timescale 1ns/1ps
`include "slts_map.svh"
module slts_modem (
  input wire logic sys_clk,
  output logic line_rx,
  output logic line_rx_clk,
  output logic line_ack
);
  logic busy = 1'b0; // High inside a frame
  logic ack_on = 1'b0; // Remote acknowledge, set by the bench
  initial line_rx = 1'b1;
  initial line_rx_clk = 1'b0;
  assign line_ack = ack_on;

  // Idle data toggles so a stale level never looks valid
  always @(posedge sys_clk) begin
    if (!busy) begin
      line_rx <= ~line_rx;
    end
  end

  // Reference cyclic code, MSB first, zero start
  function automatic logic [11:0] crc12(input logic [11:0] w);
    logic [11:0] c;
    c = 12'h000;
    for (int i = 11; i >= 0; i--) begin
      c = (c[11] ^ w[i]) ? {c[10:0], 1'b0} ^ `SLTS_CRC_POLY : {c[10:0], 1'b0};
    end
    return c;
  endfunction

  // One frame of 36 bits, 17 cycles each; clock stands low outside it
  task automatic send_frame(input logic [11:0] w, input logic bad);
    logic [35:0] f;
    f = {`SLTS_SYNC_WORD, w, crc12(w) ^ {11'h000, bad}};
    busy = 1'b1;
    for (int i = 35; i >= 0; i--) begin
      @(posedge sys_clk);
      line_rx <= f[i];
      repeat (8) @(posedge sys_clk);
      line_rx_clk <= 1'b1;
      repeat (8) @(posedge sys_clk);
      line_rx_clk <= 1'b0;
    end
    busy = 1'b0;
  endtask
endmodule

// file: verification/testbench.sv
// Self-checking bench for the serial link test sequencer
// Assumes slts_top with the far-side model; one 50 MHz clock
`timescale 1ns/1ps
`include "slts_map.svh"
module testbench;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0; // Active low
  logic [7:0] addr = 8'h00;
  logic [31:0] wr_data = 32'h0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic manual_clear = 1'b0;
  logic [31:0] rd_data;
  logic line_rx;
  logic line_rx_clk;
  logic line_ack;
  logic tx_line;
  logic tx_ind;
  logic rx_ind;
  logic irq;
  int failures = 0;
  int n_compared = 0;
  int k;
  logic [31:0] got; // Last read word
  logic [35:0] fr; // Last captured frame
  logic [11:0] w;
  // Test words per selector position
  localparam logic [11:0] TW [4] = '{12'h000, 12'hFFF, 12'h06D, 12'hF92};

  always #10 sys_clk = ~sys_clk;

  slts_top i_slts_top (.sys_clk(sys_clk), .rst_b(rst_b), .addr(addr),
    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
    .line_rx(line_rx), .line_rx_clk(line_rx_clk), .line_ack(line_ack),
    .manual_clear(manual_clear), .tx_line(tx_line), .tx_ind(tx_ind),
    .rx_ind(rx_ind), .irq(irq));

  slts_modem i_slts_modem (.sys_clk(sys_clk), .line_rx(line_rx),
    .line_rx_clk(line_rx_clk), .line_ack(line_ack));

  // Compare and count
  task automatic check(input string what, input logic [35:0] exp,
                       input logic [35:0] act);
    n_compared++;
    if (act !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, act);
    end
  endtask

  // Verdict and end of run
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // One-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge sys_clk);
    wr_en <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge sys_clk);
    rd_en <= 1'b0;
    @(negedge sys_clk);
    d = rd_data;
  endtask

  // Capture 36 bits mid-bit; hunt waits for the sync word's first 0
  task automatic get_frame(input logic hunt, output logic [35:0] f);
    if (hunt) begin
      for (int i = 0; i < 1500 && tx_line !== 1'b0; i++) @(negedge sys_clk);
      repeat (8) @(negedge sys_clk);
    end
    for (int i = 35; i >= 0; i--) begin
      f[i] = tx_line;
      repeat (16) @(negedge sys_clk);
    end
  endtask

  // Bounded wait for the transmitter to fall idle
  task automatic wait_idle();
    for (int i = 0; i < 900 && tx_ind !== 1'b0; i++) @(negedge sys_clk);
    repeat (100) @(negedge sys_clk);
    check("tx idle line", 36'h1, 36'(tx_line));
    check("tx idle ind", 36'h0, 36'(tx_ind));
  endtask

  function automatic logic [35:0] exp_fr(input logic [11:0] x);
    return {`SLTS_SYNC_WORD, x, i_slts_modem.crc12(x)};
  endfunction

  // Watchdog, well beyond the expected span of about 15000 cycles
  initial begin
    repeat (60000) @(posedge sys_clk);
    failures++;
    conclude();
  end

  initial begin
    void'($urandom(32'h5ec799f6));
    repeat (16) @(posedge sys_clk);
    rst_b <= 1'b1;
    // Reset values, then an unmapped place
    for (k = 0; k < 5; k++) begin
      rd(8'(k * 4), got);
      check("reg reset", 36'h0, 36'(got));
    end
    wr(`SLTS_ADDR_MASK, 32'h1);
    // Every selector position, two frames each, ack only on the last
    for (k = 1; k < 5; k++) begin
      i_slts_modem.ack_on <= (k == 4);
      wr(`SLTS_ADDR_CTRL, 32'(k));
      get_frame(1'b1, fr);
      check("test frame", exp_fr(TW[k-1]), fr);
      check("tx indicator", 36'h1, 36'(tx_ind));
      get_frame(1'b0, fr);
      check("repeat frame", exp_fr(TW[k-1]), fr);
      wr(`SLTS_ADDR_CTRL, 32'h0);
      wait_idle();
      rd(`SLTS_ADDR_STATUS, got);
      check("tx status", 36'({k == 4, 4'h1}), 36'(got[4:0]));
      check("irq set", 36'h1, 36'(irq));
      wr(`SLTS_ADDR_STATUS, 32'h1F);
      repeat (2) @(negedge sys_clk);
      check("irq clear", 36'h0, 36'(irq));
    end
    i_slts_modem.ack_on <= 1'b0;
    // Receive check, good and corrupted code words alternate
    wr(`SLTS_ADDR_CTRL, 32'h10);
    for (k = 0; k < 6; k++) begin
      w = (k < 2) ? TW[k] : 12'($urandom);
      fork
        i_slts_modem.send_frame(w, k[0]);
        begin
          repeat (300) @(negedge sys_clk);
          check("rx indicator", 36'h1, 36'(rx_ind));
        end
      join
      repeat (8) @(negedge sys_clk);
      rd(`SLTS_ADDR_STATUS, got);
      check("rx status", 36'({k[0], 2'b10}), 36'(got[2:0]));
      check("irq masked", 36'h0, 36'(irq));
      rd(`SLTS_ADDR_STATE, got);
      check("rx word", 36'(w), 36'(got[27:16]));
      wr(`SLTS_ADDR_STATUS, 32'h1F);
    end
    // Interrupt word detection, then a word that is not it
    wr(`SLTS_ADDR_CTRL, 32'h20);
    for (k = 0; k < 2; k++) begin
      w = (k == 0) ? 12'h06D : (12'($urandom) | 12'h800);
      i_slts_modem.send_frame(w, 1'b0);
      repeat (8) @(negedge sys_clk);
      rd(`SLTS_ADDR_STATUS, got);
      check("int detect", 36'(k == 0), 36'(got[3]));
      wr(`SLTS_ADDR_STATUS, 32'h1F);
    end
    // Manual clear in mid-frame
    wr(`SLTS_ADDR_CTRL, 32'h1);
    repeat (200) @(posedge sys_clk);
    manual_clear <= 1'b1;
    repeat (6) @(negedge sys_clk);
    check("clear line", 36'h1, 36'(tx_line));
    check("clear ind", 36'h0, 36'(tx_ind));
    rd(`SLTS_ADDR_STATE, got);
    check("clear state", 36'h0, 36'(got[5:0]));
    wr(`SLTS_ADDR_CTRL, 32'h0);
    manual_clear <= 1'b0;
    wait_idle();
    // Software clear pulse cuts a frame at once, not at its end
    wr(`SLTS_ADDR_CTRL, 32'h1);
    repeat (200) @(posedge sys_clk);
    wr(`SLTS_ADDR_CTRL, 32'h100);
    repeat (3) @(negedge sys_clk);
    check("soft clear ind", 36'h0, 36'(tx_ind));
    check("soft clear line", 36'h1, 36'(tx_line));
    // Alternate: send one frame, wait for one, send again
    wr(`SLTS_ADDR_CTRL, 32'h12);
    get_frame(1'b1, fr);
    check("alt frame 1", exp_fr(TW[1]), fr);
    repeat (200) @(negedge sys_clk);
    check("alt waits", 36'h1, 36'(tx_line));
    i_slts_modem.send_frame(12'($urandom), 1'b0);
    get_frame(1'b1, fr);
    check("alt frame 2", exp_fr(TW[1]), fr);
    wr(`SLTS_ADDR_CTRL, 32'h0);
    wait_idle();
    conclude();
  end
endmodule
